// ===== shared/css_regs.svh
// Constants of the card session sequencer: offsets, fields, resets, timing.
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH

// Reference clock rate in MHz.
`define CSS_CLK_MHZ 125
// Activation step of 500 ns, rounded up to whole cycles.
`define CSS_STEP_NS 500
`define CSS_STEP_CYC ((`CSS_STEP_NS * `CSS_CLK_MHZ + 999) / 1000)
// Delay from card reset low to card clock low, 12 us.
`define CSS_DEACT_US 12
`define CSS_DEACT_CYC (`CSS_DEACT_US * `CSS_CLK_MHZ)
// Reset-input clock-gating window, 200 us.
`define CSS_WINDOW_US 200
`define CSS_WINDOW_CYC (`CSS_WINDOW_US * `CSS_CLK_MHZ)
// Card presence debounce, 8 ms.
`define CSS_DEBOUNCE_MS 8
`define CSS_DEBOUNCE_CYC (`CSS_DEBOUNCE_MS * 1000 * `CSS_CLK_MHZ)

// Half-period counts of the card clock divider, minus one.
`define CSS_DIV8_LIM 2'h3
`define CSS_DIV4_LIM 2'h1
`define CSS_DIV2_LIM 2'h0

// Register byte offsets.
`define CSS_REG_EVENT 4'h0
`define CSS_REG_MASK 4'h4
`define CSS_REG_STATE 4'h8

// Event bit positions, shared by the event and mask registers.
`define CSS_EV_INSERT 0
`define CSS_EV_REMOVE 1
`define CSS_EV_FAULT 2
`define CSS_EV_ACTIVE 3
`define CSS_EV_DONE 4
`define CSS_EV_COUNT 5

// Reset values.
`define CSS_EVENT_RST 5'h00
`define CSS_MASK_RST 5'h00

`endif

// ===== shared/css_pkg.sv
// Types of the card session sequencer.
`default_nettype none
package css_pkg;
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_RAMP,
        ST_IO,
        ST_CLK,
        ST_ACTIVE,
        ST_DEACT_RST,
        ST_DEACT_IO,
        ST_DEACT_PWR
    } css_state_t;
endpackage : css_pkg
`default_nettype wire

// ===== logic/css_clk_div.sv
// Card clock divider with selectable ratio and a stop-low run input.
`timescale 1ns/1ps
`default_nettype none
`include "css_regs.svh"
module css_clk_div (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Control.
    input wire logic run,
    input wire logic divider_select_hi,
    input wire logic divider_select_lo,
    // Card clock.
    output logic card_clock_out,
    output logic card_clock_bypass
);
    logic [1:0] cnt;
    wire [1:0] sel = {divider_select_hi, divider_select_lo};
    wire div_one = (sel == 2'b10);
    wire [1:0] lim = (sel == 2'b00) ? `CSS_DIV8_LIM :
                     (sel == 2'b01) ? `CSS_DIV4_LIM : `CSS_DIV2_LIM;

    // The divided clock toggles each lim+1 cycles and parks low when stopped.
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !run || div_one) begin
            cnt <= 2'h0;
            card_clock_out <= 1'b0;
        end else if (cnt == lim) begin
            cnt <= 2'h0;
            card_clock_out <= ~card_clock_out;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end

    // Divide by one hands the reference clock to the pad mux instead.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            card_clock_bypass <= 1'b0;
        end else begin
            card_clock_bypass <= run & div_one;
        end
    end
endmodule : css_clk_div
`default_nettype wire

// ===== logic/css_sequencer.sv
// Card session sequencer: activation, deactivation, presence and faults.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "css_regs.svh"

// Overview of operation
// - After reset sit idle: card lines low, host lines released, monitors live.
// - While session request is high, interrupt line shows debounced card presence.
// - Card signals stay low until the card supply reports good.
// - Supply good, then I/O lines, clock 500 ns later, reset 500 ns later.
// - In gating mode the clock starts when reset input falls in window.
// - Gating mode: card reset low until 200 us, then mirrors reset input.
// - Normal mode: clock 500 ns after I/O, reset follows input later.
// - Session end: reset low, clock low 12 us later, I/O low, supply off.
// - Detect removal, main, card supply, regulator undervoltage, overload, heat.
// - Pin current limiting is neither reported nor counted as a fault.
// - Idle with card, main undervoltage pulls interrupt low until recovery.
// - In a session any fault pulls interrupt low and deactivates at once.
// - Insertion raises the interrupt line only after 8 ms of presence.
// - Removal deactivates and drops the interrupt line at once.
// - Card clock is the reference divided by 8, 4, 1 or 2 by select pins.
module css_sequencer #(
    parameter int unsigned WINDOW_CYC = `CSS_WINDOW_CYC,
    parameter int unsigned DEBOUNCE_CYC = `CSS_DEBOUNCE_CYC
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Host control lines.
    input wire logic session_request_n,
    input wire logic host_card_reset_in,
    input wire logic divider_select_hi,
    input wire logic divider_select_lo,
    // Card presence and monitors.
    input wire logic card_detect_pin,
    input wire logic card_supply_good,
    input wire logic main_supply_low,
    input wire logic card_supply_overload,
    input wire logic card_supply_out_of_range,
    input wire logic regulator_input_supply_low,
    input wire logic over_temperature,
    // Card side controls.
    output logic card_supply_en,
    output logic card_lines_en,
    output logic card_clock_out,
    output logic card_clock_bypass,
    output logic card_reset_out,
    // Host side.
    output logic host_lines_release,
    output logic host_int_n,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq
);
    css_pkg::css_state_t state;
    css_pkg::css_state_t next_state;
    logic req_prev;
    logic gate_mode;
    logic gate_clk;
    logic window_done;
    logic clk_run;
    logic present;
    logic fault_hold;
    logic [10:0] tmr;
    logic [14:0] win_cnt;
    logic [19:0] deb_cnt;
    logic [`CSS_EV_COUNT-1:0] events;
    logic [`CSS_EV_COUNT-1:0] mask;
    logic [`CSS_EV_COUNT-1:0] ev_set;

    // Session decode and fault gathering.
    wire fault_any = main_supply_low | card_supply_overload |
        card_supply_out_of_range | regulator_input_supply_low |
        over_temperature;
    wire in_session = (state == css_pkg::ST_RAMP) ||
        (state == css_pkg::ST_IO) || (state == css_pkg::ST_CLK) ||
        (state == css_pkg::ST_ACTIVE);
    wire fault_evt = in_session & (fault_any | ~card_detect_pin);
    wire abort = fault_evt | (in_session & session_request_n);
    wire req_fall = req_prev & ~session_request_n;
    wire start = (state == css_pkg::ST_STANDBY) & req_fall & present &
        ~main_supply_low & ~fault_hold;
    wire step_done = (tmr == 11'(`CSS_STEP_CYC - 1));
    wire deact_done = (tmr == 11'(`CSS_DEACT_CYC - 1));
    wire win_end = (win_cnt == 15'(WINDOW_CYC - 1));
    wire deb_end = (deb_cnt == 20'(DEBOUNCE_CYC - 1));
    // Lines stay driven through the clock stop only if they were on, so an
    // abort during the supply ramp never drives the card lines.
    wire lines_on = (state == css_pkg::ST_IO) ||
        (state == css_pkg::ST_CLK) || (state == css_pkg::ST_ACTIVE) ||
        ((state == css_pkg::ST_DEACT_RST) & card_lines_en);
    wire supply_on = in_session || (state == css_pkg::ST_DEACT_RST) ||
        (state == css_pkg::ST_DEACT_IO);

    // Clock run and card reset decode for both activation modes.
    wire gate_start = gate_mode & lines_on & in_session &
        (~host_card_reset_in | win_end | window_done);
    wire normal_clk = ~gate_mode & ((state == css_pkg::ST_CLK) ||
        (state == css_pkg::ST_ACTIVE));
    wire next_clk_run = (in_session & ((gate_mode & (gate_clk | gate_start)) |
        normal_clk)) | ((state == css_pkg::ST_DEACT_RST) & clk_run &
        ~deact_done);
    wire reset_ok = gate_mode ? window_done :
        (state == css_pkg::ST_ACTIVE);
    wire next_card_reset = in_session & reset_ok &
        host_card_reset_in & ~abort;
    wire next_int_n = present & card_detect_pin & ~main_supply_low &
        ~fault_hold & ~fault_evt;

    // Sequencer state transitions.
    always_comb begin
        next_state = state;
        case (state)
            css_pkg::ST_STANDBY: begin
                if (start) begin
                    next_state = css_pkg::ST_RAMP;
                end
            end
            css_pkg::ST_RAMP: begin
                if (abort) begin
                    next_state = css_pkg::ST_DEACT_RST;
                end else if (card_supply_good) begin
                    next_state = css_pkg::ST_IO;
                end
            end
            css_pkg::ST_IO: begin
                if (abort) begin
                    next_state = css_pkg::ST_DEACT_RST;
                end else if (step_done) begin
                    next_state = css_pkg::ST_CLK;
                end
            end
            css_pkg::ST_CLK: begin
                if (abort) begin
                    next_state = css_pkg::ST_DEACT_RST;
                end else if (step_done) begin
                    next_state = css_pkg::ST_ACTIVE;
                end
            end
            css_pkg::ST_ACTIVE: begin
                if (abort) begin
                    next_state = css_pkg::ST_DEACT_RST;
                end
            end
            css_pkg::ST_DEACT_RST: begin
                if (deact_done) begin
                    next_state = css_pkg::ST_DEACT_IO;
                end
            end
            css_pkg::ST_DEACT_IO: begin
                if (step_done) begin
                    next_state = css_pkg::ST_DEACT_PWR;
                end
            end
            css_pkg::ST_DEACT_PWR: begin
                next_state = css_pkg::ST_STANDBY;
            end
            default: begin
                next_state = css_pkg::ST_STANDBY;
            end
        endcase
    end

    // State register and the step timer, which restarts on each move.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= css_pkg::ST_STANDBY;
            tmr <= 11'h000;
        end else begin
            state <= next_state;
            tmr <= (next_state != state) ? 11'h000 : tmr + 11'h001;
        end
    end

    // Mode is latched from the reset input when the session opens.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            req_prev <= 1'b1;
            gate_mode <= 1'b0;
        end else begin
            req_prev <= session_request_n;
            if (start) begin
                gate_mode <= host_card_reset_in;
            end
        end
    end

    // The gating window runs from I/O activation for 200 us.
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !in_session) begin
            win_cnt <= 15'h0000;
            window_done <= 1'b0;
            gate_clk <= 1'b0;
        end else begin
            if (gate_start) begin
                gate_clk <= 1'b1;
            end
            if (lines_on && !window_done) begin
                if (win_end) begin
                    window_done <= 1'b1;
                end else begin
                    win_cnt <= win_cnt + 15'h0001;
                end
            end
        end
    end

    // Presence debounce: slow on insertion, immediate on removal.
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !card_detect_pin) begin
            deb_cnt <= 20'h0_0000;
            present <= 1'b0;
        end else if (!present) begin
            if (deb_end) begin
                present <= 1'b1;
            end else begin
                deb_cnt <= deb_cnt + 20'h0_0001;
            end
        end
    end

    // A fault keeps the interrupt low until deactivation ends and the
    // request is back high; a new fault in that cycle wins.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            fault_hold <= 1'b0;
        end else if (fault_evt) begin
            fault_hold <= 1'b1;
        end else if (state == css_pkg::ST_STANDBY && session_request_n) begin
            fault_hold <= 1'b0;
        end
    end

    // Pin drivers, all registered so that card lines idle low.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            card_supply_en <= 1'b0;
            card_lines_en <= 1'b0;
            clk_run <= 1'b0;
            card_reset_out <= 1'b0;
            host_lines_release <= 1'b1;
            host_int_n <= 1'b0;
        end else begin
            card_supply_en <= supply_on;
            card_lines_en <= lines_on;
            clk_run <= next_clk_run;
            card_reset_out <= next_card_reset;
            host_lines_release <= ~lines_on;
            host_int_n <= next_int_n;
        end
    end

    // Card clock generation from the reference clock.
    css_clk_div u_clk_div (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .run(clk_run),
        .divider_select_hi(divider_select_hi),
        .divider_select_lo(divider_select_lo),
        .card_clock_out(card_clock_out),
        .card_clock_bypass(card_clock_bypass)
    );

    // Event sources for the sticky event register.
    assign ev_set[`CSS_EV_INSERT] = card_detect_pin & ~present & deb_end;
    assign ev_set[`CSS_EV_REMOVE] = present & ~card_detect_pin;
    assign ev_set[`CSS_EV_FAULT] = fault_evt;
    assign ev_set[`CSS_EV_ACTIVE] = (state == css_pkg::ST_CLK) &
        (next_state == css_pkg::ST_ACTIVE);
    assign ev_set[`CSS_EV_DONE] = (state == css_pkg::ST_DEACT_PWR);

    // Register decode.
    wire [`CSS_EV_COUNT-1:0] ev_rst = `CSS_EVENT_RST;
    wire wr_event = reg_wr & (reg_addr == `CSS_REG_EVENT);
    wire wr_mask = reg_wr & (reg_addr == `CSS_REG_MASK);
    wire [7:0] state_word = {present, fault_hold, gate_mode, window_done,
        clk_run, card_lines_en, card_supply_en, card_reset_out};
    wire [7:0] rd_mux = (reg_addr == `CSS_REG_EVENT) ? {3'b000, events} :
        (reg_addr == `CSS_REG_MASK) ? {3'b000, mask} :
        (reg_addr == `CSS_REG_STATE) ? state_word : 8'h00;

    // Sticky event bits: a set in the clearing cycle wins.
    genvar gi;
    generate
        for (gi = 0; gi < `CSS_EV_COUNT; gi = gi + 1) begin : g_event
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    events[gi] <= ev_rst[gi];
                end else if (ev_set[gi]) begin
                    events[gi] <= 1'b1;
                end else if (wr_event && reg_wdata[gi]) begin
                    events[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mask, read data and interrupt request.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mask <= `CSS_MASK_RST;
            reg_rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            if (wr_mask) begin
                mask <= reg_wdata[`CSS_EV_COUNT-1:0];
            end
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            irq <= |(events & mask);
        end
    end
endmodule : css_sequencer
`default_nettype wire

// ===== logic/css_sequencer_end.sv
// Reserved file of the card session sequencer; it holds no logic.

// ===== testbench/css_sequencer_asserts.sv
// Port-level checks of the card session sequencer.
`timescale 1ns/1ps
`default_nettype none
module css_seq_checker #(
    parameter int unsigned WINDOW_CYC = 200,
    parameter int unsigned DEBOUNCE_CYC = 50
) (
    // Clock, reset and inputs.
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic session_request_n,
    input wire logic card_detect_pin,
    input wire logic card_supply_good,
    input wire logic main_supply_low,
    input wire logic card_supply_overload,
    input wire logic card_supply_out_of_range,
    input wire logic regulator_input_supply_low,
    input wire logic over_temperature,
    // Outputs.
    input wire logic card_supply_en,
    input wire logic card_lines_en,
    input wire logic card_reset_out,
    input wire logic host_lines_release,
    input wire logic host_int_n
);
    logic [31:0] seen_cnt;
    logic [11:0] deact_cnt;
    wire fault_now = main_supply_low | card_supply_overload
        | card_supply_out_of_range | regulator_input_supply_low
        | over_temperature;
    wire abort_now = card_supply_en
        & (session_request_n | ~card_detect_pin | fault_now);
    // Cycles since a session began to close, and since the card was seen.
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !card_supply_en) deact_cnt <= 12'h000;
        else if (deact_cnt != 12'h000 || abort_now) begin
            deact_cnt <= deact_cnt + 12'h001;
        end
        if (!rst_b || !card_detect_pin) seen_cnt <= 32'h0000_0000;
        else seen_cnt <= seen_cnt + 32'h0000_0001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    AST_RST_IDLE: assert property (
        $rose(rst_b) |-> host_lines_release && !card_supply_en
        && !card_lines_en && !card_reset_out) else $error("not idle");
    AST_LINES_SUPPLY: assert property (
        card_lines_en |-> card_supply_en) else $error("lines unpowered");
    AST_LINES_GOOD: assert property (
        $rose(card_lines_en) |-> $past(card_supply_good))
        else $error("lines before supply good");
    AST_RST_ORDER: assert property (
        $rose(card_lines_en) |-> !card_reset_out [*8])
        else $error("card reset too early");
    AST_CARD_RESET_OUT_DROP: assert property (
        $rose(session_request_n) && card_supply_en |=> !card_reset_out [*8])
        else $error("card reset not forced low");
    AST_DEACT_GAP: assert property (
        $fell(card_supply_en) |-> deact_cnt >= 12'h5dc
        && deact_cnt <= 12'h6a4) else $error("deactivation timing");
    AST_INT_DROP: assert property (
        main_supply_low || !card_detect_pin |=> !host_int_n)
        else $error("interrupt not low");
    AST_INT_FAULT: assert property (
        card_supply_en && fault_now |=> !host_int_n)
        else $error("fault not flagged");
    AST_DEBOUNCE: assert property (
        $rose(host_int_n) |-> seen_cnt >= DEBOUNCE_CYC - 1)
        else $error("presence before debounce");
    CV_OPEN: cover property ($rose(card_lines_en));
    CV_CLOSE: cover property ($fell(card_supply_en));
    CV_FAULT: cover property (card_supply_en && fault_now);
endmodule : css_seq_checker
bind css_sequencer css_seq_checker #(
    .WINDOW_CYC(WINDOW_CYC),
    .DEBOUNCE_CYC(DEBOUNCE_CYC)
) u_css_seq_checker (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .session_request_n(session_request_n),
    .card_detect_pin(card_detect_pin), .card_supply_good(card_supply_good),
    .main_supply_low(main_supply_low),
    .card_supply_overload(card_supply_overload),
    .card_supply_out_of_range(card_supply_out_of_range),
    .regulator_input_supply_low(regulator_input_supply_low),
    .over_temperature(over_temperature), .card_supply_en(card_supply_en),
    .card_lines_en(card_lines_en), .card_reset_out(card_reset_out),
    .host_lines_release(host_lines_release), .host_int_n(host_int_n)
);
`default_nettype wire

// ===== testbench/css_host_model.sv
// Host controller model driving session request and card reset input.
`timescale 1ns/1ps
`default_nettype none
module css_host_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Bench commands and device interrupt.
    input wire logic want,
    input wire logic gate,
    input wire logic [7:0] dly,
    input wire logic host_int_n,
    // Lines to the device.
    output logic session_request_n,
    output logic host_card_reset_in
);
    logic [15:0] cnt;
    // Opens only on reported presence; a fault makes it close at once.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            session_request_n <= 1'b1;
            host_card_reset_in <= 1'b0;
            cnt <= 16'h0000;
        end else if (session_request_n) begin
            cnt <= 16'h0000;
            host_card_reset_in <= gate;
            if (want && host_int_n && host_card_reset_in == gate) begin
                session_request_n <= 1'b0;
            end
        end else begin
            cnt <= cnt + 16'h0001;
            if (!want || !host_int_n) session_request_n <= 1'b1;
            if (cnt == {8'h00, dly}) begin
                host_card_reset_in <= !gate;
            end else if (cnt == {6'h00, dly, 2'h0}) begin
                host_card_reset_in <= 1'b1;
            end
        end
    end
endmodule : css_host_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench of the card session sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned DEB = 50;
    logic ref_clk, rst_b, want, gate, sel_hi, sel_lo, card_detect_pin, p;
    logic card_supply_good, card_supply_en, card_lines_en, card_clock_out;
    logic card_clock_bypass, card_reset_out, host_lines_release, host_int_n;
    logic session_request_n, host_card_reset_in, reg_wr, reg_rd, irq;
    logic [4:0] flt, sup_cnt;
    logic [7:0] dly, reg_wdata, reg_rdata, ev;
    logic [3:0] reg_addr;
    logic [31:0] seed, r;
    int fail_count, check_count, t, n;
    css_sequencer #(.WINDOW_CYC(200), .DEBOUNCE_CYC(DEB)) u_css_sequencer (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .session_request_n(session_request_n),
        .host_card_reset_in(host_card_reset_in),
        .divider_select_hi(sel_hi), .divider_select_lo(sel_lo),
        .card_detect_pin(card_detect_pin), .card_supply_good(card_supply_good),
        .main_supply_low(flt[0]), .card_supply_overload(flt[1]),
        .card_supply_out_of_range(flt[2]),
        .regulator_input_supply_low(flt[3]), .over_temperature(flt[4]),
        .card_supply_en(card_supply_en), .card_lines_en(card_lines_en),
        .card_clock_out(card_clock_out), .card_clock_bypass(card_clock_bypass),
        .card_reset_out(card_reset_out),
        .host_lines_release(host_lines_release), .host_int_n(host_int_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    css_host_model u_css_host_model (.ref_clk(ref_clk), .rst_b(rst_b),
        .want(want), .gate(gate), .dly(dly), .host_int_n(host_int_n),
        .session_request_n(session_request_n),
        .host_card_reset_in(host_card_reset_in));
    // Card supply settles 21 cycles after it is switched on.
    always @(posedge ref_clk) begin
        sup_cnt <= card_supply_en ? sup_cnt + {4'h0, sup_cnt != 5'h14} : 5'h00;
        card_supply_good <= card_supply_en && sup_cnt == 5'h14;
    end
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Rising card clock edges in 64 reference cycles for each ratio.
    function automatic logic [7:0] rises(input logic [1:0] s);
        return (s == 2'b00) ? 8'h08 : (s == 2'b01) ? 8'h10 :
            (s == 2'b11) ? 8'h20 : 8'h00;
    endfunction : rises
    function automatic logic [7:0] evx(input int k);
        return 8'h10 | ((k != 0) ? 8'h04 : 8'h00) | ((k == 6) ? 8'h02 : 8'h00);
    endfunction : evx
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic at(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : at
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // One session; k 0 closes normally, 1 to 5 raise a monitor, 6 pulls card.
    task automatic session(input int k);
        r = xs();
        gate <= r[0];
        {sel_hi, sel_lo} <= k[1:0];
        dly <= 8'h46 + {2'h0, r[8:3]};
        want <= 1'b1;
        t = 0;
        while (card_lines_en !== 1'b1 && t < 300) begin
            at(1);
            t++;
        end
        chk(card_supply_good, 1'b1);
        at(40);
        chk({card_clock_out, card_clock_bypass, card_reset_out}, 8'h00);
        chk(host_lines_release, 1'b0);
        at(100);
        n = 0;
        repeat (64) begin
            p = card_clock_out;
            at(1);
            n += (card_clock_out && !p);
        end
        chk(n[7:0], rises(k[1:0]));
        chk(card_clock_bypass, k[1:0] == 2'b10);
        at(6);
        chk(card_reset_out, !gate);
        at(390);
        chk(card_reset_out, 1'b1);
        rd(4'h8, ev);
        chk(ev & 8'h0f, 8'h0f);
        if (k == 0) want <= 1'b0;
        else if (k == 6) card_detect_pin <= 1'b0;
        else flt <= 5'h01 << (k - 1);
        at(2);
        chk(host_int_n, k == 0);
        chk(card_reset_out, 1'b0);
        at(1000);
        chk(card_lines_en, 1'b1);
        t = 1002;
        while (card_supply_en === 1'b1 && t < 2000) begin
            at(1);
            t++;
        end
        chk(t >= 1500 && t < 1700, 1'b1);
        want <= 1'b0;
        flt <= 5'h00;
        card_detect_pin <= 1'b1;
        at(DEB + 10);
        chk(host_int_n, 1'b1);
        rd(4'h0, ev);
        chk(ev & 8'h16, evx(k));
        chk(irq, 1'b1);
        wr(4'h0, 8'h1f);
        rd(4'h0, ev);
        chk(ev, 8'h00);
        chk(irq, 1'b0);
    endtask : session
    task automatic report_and_stop();
        if (fail_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        {seed, rst_b, want, gate, sel_hi, sel_lo} = {32'h598f_6158, 5'h00};
        {card_detect_pin, flt, dly} = 14'h0000;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 14'h0000;
        {fail_count, check_count} = 64'h0000_0000_0000_0000;
        at(2);
        rst_b <= 1'b1;
        at(1);
        chk({host_lines_release, host_int_n, card_supply_en}, 8'h04);
        rd(4'hc, ev);
        chk(ev, 8'h00);
        card_detect_pin <= 1'b1;
        at(DEB - 5);
        chk(host_int_n, 1'b0);
        at(10);
        chk({host_int_n, irq}, 8'h02);
        wr(4'h4, 8'h1f);
        wr(4'hc, 8'h00);
        rd(4'h4, ev);
        chk(ev, 8'h1f);
        chk(irq, 1'b1);
        flt <= 5'h01;
        at(2);
        chk(host_int_n, 1'b0);
        flt <= 5'h00;
        at(2);
        chk(host_int_n, 1'b1);
        wr(4'h0, 8'h1f);
        for (int k = 0; k < 7; k++) session(k);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
